// ### common/psb_pkg.sv
// Constants for the pipelined SRAM burst port.
// Assumes one clock; all users import the whole package.
package psb_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 19;
  localparam int LANES   = 4;
  localparam int LANE_W  = 9;
  localparam int DATA_W  = LANES * LANE_W;
  localparam int BURST_W = 2;
  localparam int WQ_DEPTH = 32;
  localparam int WQ_W    = ADDR_W + LANES + DATA_W;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [BURST_W-1:0] BURST_FIRST = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP  = 2'h1;
  localparam logic               ORDER_LINEAR = 1'h0;

  // Address of the n-th beat of a burst, linear or interleaved
  function automatic logic [ADDR_W-1:0] psb_beat_addr(
    input logic [ADDR_W-1:0]  base,
    input logic [BURST_W-1:0] beat,
    input logic               order
  );
    logic [BURST_W-1:0] low;
    low = (order == ORDER_LINEAR) ? BURST_W'(base[BURST_W-1:0] + beat)
                                  : (base[BURST_W-1:0] ^ beat);
    return {base[ADDR_W-1:BURST_W], low};
  endfunction
endpackage

// ### hw/psb_port.sv
// Pipelined SRAM burst port: command pipe, burst counter, write queue,
// storage array and registered data bus.
// Assumes inputs synchronous to core_clk and a controller on the far side.
//
// Function
// (R1) Bursts step low two address bits, four words
// (R2) Load cycle ends burst, takes new address
// (R3) Read/write select ignored while bursting
// (R4) Burst direction fixed at its load cycle
// (R5) Write starts on selected load with select low
// (R6) Controller gives byte selects every write beat
// (R7) Write data paired two cycles after command
// (R8) Clock enable high makes edge never happen
// (R9) Suppressed edge keeps every internal register
// (R10) Controller drives three chip selects together
// (R11) Data bus released from first edge on
// (R12) Read data driven two cycles after request
// (R13) Deselected load starts nothing, releases bus later
`timescale 1ns/1ns
`default_nettype none

// ------------------------------------------------------------------
// Write queue
// ------------------------------------------------------------------
module psb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [PW-1:0]    rd_ptr;
  logic [PW-1:0]    wr_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = count != (PW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = store[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (push) begin
      store[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= PW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= PW'(rd_ptr + 1'b1);
      end
      count <= (PW+1)'(count + push - pop);
    end
  end
endmodule

// ------------------------------------------------------------------
// Port top
// ------------------------------------------------------------------
module psb_port
  import psb_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              clock_enable_n,
  input  wire logic              advance_or_load,
  input  wire logic              read_write_n,
  input  wire logic              chip_select_a_n,
  input  wire logic              chip_select_b,
  input  wire logic              chip_select_c_n,
  input  wire logic              burst_order_select,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [LANES-1:0]  byte_lane_write_n,
  input  wire logic [DATA_W-1:0] data_in,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_oe
);
  logic              en;
  logic              selected;
  logic              load;
  logic              advance;
  logic              burst_active;
  logic              burst_write;
  logic [ADDR_W-1:0] burst_base;
  logic [BURST_W-1:0] burst_cnt;
  logic [BURST_W-1:0] next_cnt;
  logic              s1_valid;
  logic              s1_write;
  logic [ADDR_W-1:0] s1_addr;
  logic [LANES-1:0]  s1_bw_n;
  logic              s2_valid;
  logic              s2_write;
  logic [ADDR_W-1:0] s2_addr;
  logic [LANES-1:0]  s2_bw_n;
  logic [DATA_W-1:0] rd_data;
  logic              array_read;
  logic              wq_push;
  logic              wq_in_ready;
  logic              wq_out_valid;
  logic              wq_pop;
  logic [WQ_W-1:0]   wq_out;
  logic [ADDR_W-1:0] wq_addr;
  logic [LANES-1:0]  wq_bw_n;
  logic [DATA_W-1:0] wq_data;
  logic [DATA_W-1:0] mem [2**ADDR_W];

  // Every register below is gated by en, so a blocked edge changes nothing
  assign en         = !clock_enable_n; // R8
  assign selected   = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  assign load       = en && !advance_or_load; // R2
  assign advance    = en && advance_or_load && burst_active;
  assign next_cnt   = BURST_W'(burst_cnt + BURST_STEP);
  assign array_read = en && s1_valid && !s1_write;
  assign wq_push    = en && s2_valid && s2_write; // R7
  assign wq_pop     = en && !array_read && wq_out_valid;
  assign {wq_addr, wq_bw_n, wq_data} = wq_out;

  // ----------------------------------------------------------------
  // Burst control
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      burst_active <= 1'b0;
      burst_write  <= 1'b0;
      burst_base   <= '0;
      burst_cnt    <= BURST_FIRST;
    end else if (load) begin
      // Deselected load leaves nothing to advance
      burst_active <= selected; // R13
      burst_write  <= !read_write_n; // R4
      burst_base   <= addr;
      burst_cnt    <= BURST_FIRST;
    end else if (advance) begin
      // Counter wraps after the fourth word
      burst_cnt <= next_cnt; // R1
    end
  end

  // ----------------------------------------------------------------
  // Command pipe
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s1_valid <= 1'b0;
      s1_write <= 1'b0;
      s2_valid <= 1'b0;
      s2_write <= 1'b0;
    end else if (en) begin // R9
      if (load) begin
        s1_valid <= selected; // R13
        s1_write <= !read_write_n; // R5
      end else begin
        s1_valid <= burst_active;
        s1_write <= burst_write; // R3
      end
      s2_valid <= s1_valid;
      s2_write <= s1_write;
    end
  end

  // Byte selects travel with the beat they arrived on
  always_ff @(posedge core_clk) begin
    if (en) begin
      s1_addr <= load ? addr
                      : psb_beat_addr(burst_base, next_cnt, burst_order_select); // R1
      s1_bw_n <= byte_lane_write_n;
      s2_addr <= s1_addr;
      s2_bw_n <= s1_bw_n;
    end
  end

  // ----------------------------------------------------------------
  // Write queue and storage
  // ----------------------------------------------------------------
  psb_fifo #(
    .WIDTH (WQ_W),
    .DEPTH (WQ_DEPTH)
  ) u_wq (
    .core_clk  (core_clk),
    .srst      (srst),
    .in_valid  (wq_push),
    .in_ready  (wq_in_ready),
    .in_data   ({s2_addr, s2_bw_n, data_in}),
    .out_valid (wq_out_valid),
    .out_ready (wq_pop),
    .out_data  (wq_out)
  );

  // Single array port: a read beat wins, queued writes drain in gaps.
  // Limitation: a read does not see writes still waiting in the queue.
  always_ff @(posedge core_clk) begin
    if (array_read) begin
      rd_data <= mem[s1_addr];
    end else if (wq_pop) begin
      for (int i = 0; i < LANES; i++) begin
        if (!wq_bw_n[i]) begin
          mem[wq_addr][i*LANE_W +: LANE_W] <= wq_data[i*LANE_W +: LANE_W];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Data bus
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (srst) begin
      data_oe  <= 1'b0; // R11
      data_out <= '0;
    end else if (en) begin
      data_oe  <= s2_valid && !s2_write; // R12
      data_out <= rd_data;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence seq_sel_load;
    en && !advance_or_load && selected;
  endsequence

  sequence seq_read_cmd;
    en && !advance_or_load && selected && read_write_n;
  endsequence

  sequence seq_write_cmd;
    en && !advance_or_load && selected && !read_write_n;
  endsequence

  sequence seq_two_live_edges;
    ##1 en ##1 en;
  endsequence

  chk_burst_step: assert property ( // R1
    advance |=> s1_valid && s1_addr == psb_beat_addr($past(burst_base),
      BURST_W'($past(burst_cnt) + BURST_STEP), $past(burst_order_select)))
    else $error("burst address not stepped");

  chk_load_addr: assert property ( // R2
    seq_sel_load |=> s1_valid && s1_addr == $past(addr) && burst_cnt == BURST_FIRST)
    else $error("load did not take new address");

  chk_rw_ignored: assert property ( // R3
    advance |=> s1_write == burst_write)
    else $error("read/write select used during burst");

  chk_dir_fixed: assert property ( // R4
    seq_sel_load |=> burst_write == !$past(read_write_n))
    else $error("burst direction not fixed at load");

  chk_write_start: assert property ( // R5
    seq_write_cmd |=> s1_valid && s1_write)
    else $error("write not started");

  chk_write_pair: assert property ( // R7
    seq_write_cmd ##0 seq_two_live_edges |-> wq_push)
    else $error("write data not paired two cycles later");

  // Queue has no back-pressure to the pins, so a full queue would lose a write
  chk_queue_room: assert property ( // R7
    wq_push |-> wq_in_ready)
    else $error("write queue overflowed");

  chk_edge_frozen: assert property ( // R8
    !en |=> $stable(s1_addr) && $stable(s2_valid) && $stable(burst_cnt))
    else $error("register moved on blocked edge");

  chk_bus_frozen: assert property ( // R9
    !en |=> $stable(data_oe) && $stable(data_out))
    else $error("data bus moved on blocked edge");

  chk_hiz_reset: assert property ( // R11
    @(posedge core_clk) disable iff (1'b0) srst |=> !data_oe)
    else $error("data bus driven after reset edge");

  chk_read_lat: assert property ( // R12
    seq_read_cmd ##0 seq_two_live_edges |=> data_oe)
    else $error("read data not driven on time");

  chk_deselect: assert property ( // R13
    en && !advance_or_load && !selected ##0 seq_two_live_edges |=> !data_oe)
    else $error("deselected cycle drove the bus");
endmodule

`default_nettype wire

// ### test/psb_ctrl_model.sv
// Controller model: chip selects and write data for the burst port.
// Assumes the bench gives command fields just after a falling edge.
`timescale 1ns/1ns
`default_nettype none
module psb_ctrl_model
  import psb_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              clock_enable_n,
  input  wire logic              sel,
  input  wire logic              wv,
  input  wire logic [DATA_W-1:0] wd,
  output logic                   chip_select_a_n,
  output logic                   chip_select_b,
  output logic                   chip_select_c_n,
  output logic      [DATA_W-1:0] data_in
);
  logic [1:0]        v  = 2'h0;
  logic [DATA_W-1:0] d1 = '0;
  logic [DATA_W-1:0] d2 = '0;

  assign chip_select_a_n = ~sel;
  assign chip_select_b   = sel;
  assign chip_select_c_n = ~sel;
  // Released bus shows the inverse, so a stale word never matches
  assign data_in = v[1] ? d2 : ~d2;

  // Blocked edges must not move the data pipe either
  always_ff @(posedge core_clk) begin
    if (!clock_enable_n) begin
      v  <= {v[0], wv};
      d1 <= wd;
      d2 <= d1;
    end
  end
endmodule
`default_nettype wire

// ### test/pipelined_sram_burst_port_tb.sv
// Bench for the SRAM burst port: bursts, aborts, lanes, blocked edges.
// Assumes psb_pkg and the controller model beside it.
`timescale 1ns/1ns
`default_nettype none
module pipelined_sram_burst_port_tb;
  import psb_pkg::*;
  logic              core_clk = 1'b0;
  logic              srst     = 1'b1;
  logic              en_n     = 1'b0;
  logic              ld       = 1'b1;
  logic              rd       = 1'b1;
  logic              sel      = 1'b0;
  logic              wv       = 1'b0;
  logic              order    = 1'b0;
  logic              prev_en  = 1'b1;
  logic [ADDR_W-1:0] a        = '0;
  logic [LANES-1:0]  bw       = '1;
  logic [DATA_W-1:0] wd       = '0;
  logic              cs_a_n, cs_b, cs_c_n, data_oe, act, wr;
  logic [DATA_W-1:0] data_in, data_out;
  logic [ADDR_W-1:0] base;
  logic [1:0]        beat;
  logic [DATA_W:0]   last = '0;
  logic [DATA_W:0]   q[$];
  logic [DATA_W-1:0] mem[logic [ADDR_W-1:0]];
  int                n_errors = 0;
  int                n_tests  = 0;

  always #2 core_clk = ~core_clk;

  psb_ctrl_model ctrl (.core_clk(core_clk), .clock_enable_n(en_n), .sel(sel), .wv(wv),
    .wd(wd), .chip_select_a_n(cs_a_n), .chip_select_b(cs_b), .chip_select_c_n(cs_c_n),
    .data_in(data_in));
  psb_port DUT (.core_clk(core_clk), .srst(srst), .clock_enable_n(en_n),
    .advance_or_load(~ld), .read_write_n(rd), .chip_select_a_n(cs_a_n),
    .chip_select_b(cs_b), .chip_select_c_n(cs_c_n), .burst_order_select(order),
    .addr(a), .byte_lane_write_n(bw), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe));

  task automatic chk(input string what, input logic [DATA_W-1:0] exp, got);
    n_tests++;
    if (exp !== got) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Expected bus state lags each counted edge by three falling edges
  task automatic step(input logic e, l, r, s, input logic [ADDR_W-1:0] ad,
                      input logic [LANES-1:0] b, input logic [DATA_W-1:0] d);
    logic [ADDR_W-1:0] x;
    logic [DATA_W:0]   ex;
    @(negedge core_clk);
    if (prev_en && q.size() == 3)
      last = q.pop_front();
    chk("oe", DATA_W'(last[DATA_W]), DATA_W'(data_oe));
    if (last[DATA_W])
      chk("data", last[DATA_W-1:0], data_out);
    prev_en = e;
    en_n = ~e;
    ld = l;
    rd = r;
    sel = s;
    a = ad;
    bw = b;
    wd = d;
    wv = 1'b0;
    ex = '0;
    if (e) begin
      if (l) begin
        act = s;
        wr = ~r;
        base = ad;
        beat = 2'h0;
      end else
        beat = beat + 2'h1;
      x = {base[ADDR_W-1:2], order ? base[1:0] ^ beat : base[1:0] + beat};
      if (act && wr) begin
        wv = 1'b1;
        for (int i = 0; i < LANES; i++)
          if (!b[i])
            mem[x][i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
      end else if (act)
        ex = {1'b1, mem[x]};
      q.push_back(ex);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) step(1'b1, 1'b1, 1'b1, 1'b0, '0, '1, '0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_bursts();
    logic [ADDR_W-1:0] b0;
    for (int o = 0; o < 2; o++) begin
      order = o[0];
      b0 = o ? 19'h23 : 19'h11;
      for (int i = 0; i < 4; i++)
        step(1'b1, i == 0, i[0], 1'b1, b0, 4'h0, DATA_W'({o[3:0], i[3:0], 8'h5a}));
      idle(4);
      // Third edge blocked while showing a deselected load
      for (int i = 0; i < 6; i++)
        step(i != 2, i == 0 || i == 2, i == 0, i != 2, b0, '1, '0);
      idle(3);
    end
  endtask

  task automatic t_abort();
    order = 1'b0;
    step(1'b1, 1'b1, 1'b1, 1'b1, 19'h12, '1, '0);
    step(1'b1, 1'b0, 1'b1, 1'b1, '0, '1, '0);
    step(1'b1, 1'b1, 1'b1, 1'b1, 19'h21, '1, '0);
    step(1'b1, 1'b1, 1'b1, 1'b0, 19'h10, '1, '0);
    step(1'b1, 1'b0, 1'b1, 1'b1, '0, '1, '0);
    idle(3);
  endtask

  task automatic t_lanes();
    step(1'b1, 1'b1, 1'b0, 1'b1, 19'h12, 4'h5, {4{9'h1c3}});
    step(1'b1, 1'b1, 1'b1, 1'b1, 19'h10, '1, '0);
    step(1'b1, 1'b1, 1'b0, 1'b0, 19'h13, 4'h0, '1);
    idle(4);
    step(1'b1, 1'b1, 1'b1, 1'b1, 19'h12, '1, '0);
    step(1'b1, 1'b0, 1'b1, 1'b1, '0, '1, '0);
    idle(3);
  endtask

  task automatic results();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (3) q.push_back('0);
    repeat (3) @(negedge core_clk);
    chk("oe", '0, DATA_W'(data_oe));
    srst = 1'b0;
    t_bursts();
    t_abort();
    t_lanes();
    results();
  end

  // Run needs well under a microsecond
  initial begin
    #4000;
    n_errors++;
    results();
  end
endmodule
`default_nettype wire
